// ===== design/pwg_pkg.sv
// Purpose: constants for the pin waveform generator on pins 2 to 5
// Assumes: byte-wide registers reached through the on-chip register port
// Notes: each pin pair takes twelve consecutive byte addresses
//
// Contract
// - 8-bit mode: each period is five subperiods, lengths from the pin's own bytes.
// - 16-bit mode: odd pin byte is upper, even pin byte lower, of even pin subperiods.
// - Nonzero count write makes exactly that many periods, then the pin stops.
// - Zero count write makes the waveform repeat without end.
// - Count read returns periods still to go, not the written value: live, or the snapshot for a 16-bit lower read after an upper one.
// - 16-bit mode: odd count register holds upper byte, even one lower byte.
package pwg_pkg;
	localparam int SUB_NUM = 5;
	localparam int PAIR_NUM = 2;
	localparam int PIN_NUM = 4;
	localparam int CNT_W = 16;
	localparam logic [2:0] COUNT_IDX = 3'h5;
	localparam logic [15:0] PAIR_SPAN = 16'h000C;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Address of every byte; pairs share one layout: odd/upper then even/lower
	localparam logic [15:0] PIN3_SUB1_LEN = 16'h108C;
	localparam logic [15:0] PIN2_SUB1_LEN = 16'h108D;
	localparam logic [15:0] PIN3_SUB2_LEN = 16'h108E;
	localparam logic [15:0] PIN2_SUB2_LEN = 16'h108F;
	localparam logic [15:0] PIN3_SUB3_LEN = 16'h1090;
	localparam logic [15:0] PIN2_SUB3_LEN = 16'h1091;
	localparam logic [15:0] PIN3_SUB4_LEN = 16'h1092;
	localparam logic [15:0] PIN2_SUB4_LEN = 16'h1093;
	localparam logic [15:0] PIN3_SUB5_LEN = 16'h1094;
	localparam logic [15:0] PIN2_SUB5_LEN = 16'h1095;
	localparam logic [15:0] PIN3_PERIOD_COUNT = 16'h1096;
	localparam logic [15:0] PIN2_PERIOD_COUNT = 16'h1097;
	localparam logic [15:0] PIN5_SUB1_LEN = 16'h1098;
	localparam logic [15:0] PIN4_SUB1_LEN = 16'h1099;
	localparam logic [15:0] PIN5_SUB2_LEN = 16'h109A;
	localparam logic [15:0] PIN4_SUB2_LEN = 16'h109B;
	localparam logic [15:0] PIN5_SUB3_LEN = 16'h109C;
	localparam logic [15:0] PIN4_SUB3_LEN = 16'h109D;
	localparam logic [15:0] PIN5_SUB4_LEN = 16'h109E;
	localparam logic [15:0] PIN4_SUB4_LEN = 16'h109F;
	localparam logic [15:0] PIN5_SUB5_LEN = 16'h10A0;
	localparam logic [15:0] PIN4_SUB5_LEN = 16'h10A1;
	localparam logic [15:0] PIN5_PERIOD_COUNT = 16'h10A2;
	localparam logic [15:0] PIN4_PERIOD_COUNT = 16'h10A3;
	localparam logic [15:0] PAIR_BASE [PAIR_NUM] = '{PIN3_SUB1_LEN, PIN5_SUB1_LEN};
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} pwg_state_t;
endpackage

// ===== design/pwg_channel.sv
// Purpose: one waveform channel: five subperiods per period, period counting
// Assumes: lengths counted in clk cycles; start is single-cycle, halt may be held high as a level
// Notes: a subperiod of length 0 or 1 lasts one cycle
`timescale 1ns/1ns
module pwg_channel #(
	parameter int W = pwg_pkg::CNT_W
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic halt,
	input wire logic start,
	input wire logic [W-1:0] start_count,
	input wire logic [pwg_pkg::SUB_NUM-1:0][W-1:0] sub_len,
	output logic wave,
	output logic running,
	output logic [W-1:0] remaining
);
	import pwg_pkg::*;

	localparam logic [2:0] LAST_SUB = 3'(SUB_NUM - 1);

	pwg_state_t state, next_state;
	logic [2:0] sub, next_sub;
	logic [W-1:0] tick, next_tick, next_remaining;
	logic endless, next_endless;
	logic sub_done, period_done;

	assign running = (state == ST_RUN);
	assign sub_done = (tick <= W'(1));
	assign period_done = running && sub_done && (sub == LAST_SUB);

	always_comb begin
		next_state = state;
		next_sub = sub;
		next_tick = tick;
		next_remaining = remaining;
		next_endless = endless;
		unique case (state)
			ST_IDLE: begin
			end
			ST_RUN: begin
				if (!sub_done) begin
					next_tick = tick - W'(1);
				end else if (sub != LAST_SUB) begin
					next_sub = sub + 3'h1;
					next_tick = sub_len[sub + 3'h1];
				end else begin
					next_sub = 3'h0;
					next_tick = sub_len[0];
					// Endless runs keep the count at zero
					if (!endless) begin
						if (remaining == W'(1)) begin
							next_state = ST_IDLE;
							next_remaining = '0;
						end else begin
							next_remaining = remaining - W'(1);
						end
					end
				end
			end
		endcase
		if (start) begin
			next_state = ST_RUN;
			next_sub = 3'h0;
			next_tick = sub_len[0];
			next_remaining = start_count;
			next_endless = (start_count == '0);
		end
		if (halt) begin
			next_state = ST_IDLE;
			next_remaining = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			sub <= 3'h0;
			tick <= '0;
			remaining <= '0;
			endless <= 1'b0;
		end else begin
			state <= next_state;
			sub <= next_sub;
			tick <= next_tick;
			remaining <= next_remaining;
			endless <= next_endless;
		end
	end

	// Odd subperiods high, even ones low; idle pin low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wave <= 1'b0;
		end else begin
			wave <= (next_state == ST_RUN) && !next_sub[0];
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_first_sub: assert property (start && !halt |=> running && wave && tick == $past(sub_len[0]))
		else $error("first subperiod not loaded on start");
	a_sub_advance: assert property (running && sub_done && sub == 3'h0 && !start && !halt
		|=> sub == 3'h1 && !wave && tick == $past(sub_len[1]))
		else $error("second subperiod not entered");
	a_period_decr: assert property (period_done && !endless && remaining > W'(1) && !start && !halt
		|=> running && remaining == $past(remaining) - W'(1))
		else $error("period count not decremented");
	a_last_stop: assert property (period_done && !endless && remaining == W'(1) && !start && !halt
		|=> !running && !wave && remaining == '0)
		else $error("channel did not stop after last period");
	a_endless_run: assert property (running && endless && !start && !halt
		|=> running && remaining == '0)
		else $error("endless waveform stopped");

	c_finish: cover property (period_done && !endless && remaining == W'(1));
	c_endless_wrap: cover property (period_done && endless);
endmodule

// ===== design/pwg_top.sv
// Purpose: register file and four waveform channels for pins 2 to 5
// Assumes: register port and mode inputs come from logic on clk
// Notes: read data appear one cycle after the read strobe
`timescale 1ns/1ns
module pwg_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [pwg_pkg::PAIR_NUM-1:0] mode_wide,
	output logic wave_out_two,
	output logic wave_out_three,
	output logic wave_out_four,
	output logic wave_out_five
);
	import pwg_pkg::*;

	// Side 0 is the odd pin (upper byte), side 1 the even pin (lower byte)
	logic [7:0] cfg [PAIR_NUM][SUB_NUM][2];
	logic [7:0] cnt_hi [PAIR_NUM];
	logic [7:0] snap_lo [PAIR_NUM];
	logic snap_ok [PAIR_NUM];
	logic sel_hit, sel_pair, sel_side;
	logic [2:0] sel_idx;
	logic is_len, is_cnt, wide_sel;
	logic [15:0] even_rem_sel;
	logic [PIN_NUM-1:0] ch_wave, ch_run;
	logic [15:0] ch_rem [PIN_NUM];

	always_comb begin
		logic [15:0] off;
		off = '0;
		sel_hit = 1'b0;
		sel_pair = 1'b0;
		sel_idx = 3'h0;
		sel_side = 1'b0;
		for (int p = 0; p < PAIR_NUM; p++) begin
			off = reg_addr - PAIR_BASE[p];
			if (off < PAIR_SPAN) begin
				sel_hit = 1'b1;
				sel_pair = 1'(p);
				sel_idx = off[3:1];
				sel_side = off[0];
			end
		end
	end

	assign is_len = sel_hit && (sel_idx < COUNT_IDX);
	assign is_cnt = sel_hit && (sel_idx == COUNT_IDX);
	assign wide_sel = mode_wide[sel_pair];
	assign even_rem_sel = ch_rem[{sel_pair, 1'b0}];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < PAIR_NUM; p++) begin
				for (int k = 0; k < SUB_NUM; k++) begin
					cfg[p][k][0] <= REG_RESET;
					cfg[p][k][1] <= REG_RESET;
				end
			end
		end else if (reg_wr && is_len) begin
			cfg[sel_pair][sel_idx][sel_side] <= reg_wdata;
		end
	end

	// Upper count byte waits here until the lower byte write starts the pair
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_hi[0] <= REG_RESET;
			cnt_hi[1] <= REG_RESET;
		end else if (reg_wr && is_cnt && !sel_side) begin
			cnt_hi[sel_pair] <= reg_wdata;
		end
	end

	// Snapshot keeps a 16-bit count coherent across two byte reads
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			snap_lo[0] <= REG_RESET;
			snap_lo[1] <= REG_RESET;
			snap_ok[0] <= 1'b0;
			snap_ok[1] <= 1'b0;
		end else if (reg_rd && is_cnt && wide_sel) begin
			if (!sel_side) begin
				snap_lo[sel_pair] <= even_rem_sel[7:0];
				snap_ok[sel_pair] <= 1'b1;
			end else begin
				snap_ok[sel_pair] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= REG_RESET;
		end else if (reg_rd) begin
			if (!sel_hit) begin
				reg_rdata <= REG_RESET;
			end else if (is_len) begin
				reg_rdata <= cfg[sel_pair][sel_idx][sel_side];
			end else if (!sel_side) begin
				reg_rdata <= wide_sel ? even_rem_sel[15:8]
					: ch_rem[{sel_pair, 1'b1}][7:0];
			end else begin
				reg_rdata <= (wide_sel && snap_ok[sel_pair]) ? snap_lo[sel_pair]
					: even_rem_sel[7:0];
			end
		end
	end

	genvar g;
	for (g = 0; g < PIN_NUM; g++) begin : g_pin
		localparam int P = g / 2;
		localparam bit ODD = (g % 2) == 1;
		logic [SUB_NUM-1:0][15:0] lens;
		logic start;
		logic [15:0] start_count;

		always_comb begin
			for (int k = 0; k < SUB_NUM; k++) begin
				if (ODD) begin
					lens[k] = {8'h00, cfg[P][k][0]};
				end else begin
					lens[k] = {mode_wide[P] ? cfg[P][k][0] : 8'h00, cfg[P][k][1]};
				end
			end
		end

		// Odd pin of a wide pair is silent; its bytes belong to the even pin
		assign start = reg_wr && is_cnt && (sel_pair == 1'(P))
			&& (ODD ? (!sel_side && !mode_wide[P]) : sel_side);
		assign start_count = (ODD || !mode_wide[P]) ? {8'h00, reg_wdata}
			: {cnt_hi[P], reg_wdata};

		pwg_channel #(.W(16)) u_chan (
			.clk(clk),
			.nrst(nrst),
			.halt(ODD && mode_wide[P]),
			.start(start),
			.start_count(start_count),
			.sub_len(lens),
			.wave(ch_wave[g]),
			.running(ch_run[g]),
			.remaining(ch_rem[g])
		);
	end

	assign wave_out_two = ch_wave[0];
	assign wave_out_three = ch_wave[1];
	assign wave_out_four = ch_wave[2];
	assign wave_out_five = ch_wave[3];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_unmapped_read: assert property (reg_rd && !sel_hit |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_live_count: assert property (reg_rd && is_cnt && sel_side && !wide_sel
		|=> reg_rdata == $past(even_rem_sel[7:0]))
		else $error("count read not live");
	a_wide_upper: assert property (reg_rd && is_cnt && !sel_side && wide_sel
		|=> reg_rdata == $past(even_rem_sel[15:8]))
		else $error("upper count byte wrong");
	a_snap_lower: assert property ((reg_rd && is_cnt && !sel_side && wide_sel
		##1 reg_rd && is_cnt && sel_side && wide_sel && $stable(sel_pair))
		|=> reg_rdata == $past(even_rem_sel[7:0], 2))
		else $error("lower byte not from snapshot");
	a_count_start: assert property (reg_wr && is_cnt && sel_side && !wide_sel
		&& reg_wdata != 8'h00
		|=> ch_rem[{$past(sel_pair), 1'b0}] == {8'h00, $past(reg_wdata)})
		else $error("count write did not load channel");
	a_wide_start: assert property (reg_wr && is_cnt && sel_side && wide_sel
		|=> ch_rem[{$past(sel_pair), 1'b0}] == {$past(cnt_hi[sel_pair]), $past(reg_wdata)})
		else $error("16-bit count not assembled");
	a_zero_endless: assert property (reg_wr && is_cnt && sel_side && reg_wdata == 8'h00
		|=> ch_run[{$past(sel_pair), 1'b0}] ##1 ch_run[{$past(sel_pair, 2), 1'b0}])
		else $error("zero count did not run");
	a_odd_silent: assert property ((mode_wide[0] |=> !wave_out_three)
		and (mode_wide[1] |=> !wave_out_five))
		else $error("odd pin active in 16-bit mode");

	c_wide_run: cover property (mode_wide[1] && ch_run[2] && ch_rem[2] > 16'h00FF);
	c_snap_pair: cover property (reg_rd && is_cnt && !sel_side && wide_sel
		##1 reg_rd && is_cnt && sel_side);
	c_narrow_both: cover property (!mode_wide[1] && ch_run[2] && ch_run[3]);
endmodule

// ===== test/tb_pin_waveform_generator.sv
// Purpose: self-checking bench for the pin waveform generator top
// Assumes: inputs change at the falling edge; results sampled 1 ns after the rising edge
// Notes: expected read data and pin levels wait in queues for the monitor
`timescale 1ns/1ns
module tb_pin_waveform_generator;
	import pwg_pkg::*;
	logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [1:0] mode_wide = 2'h0;
	logic w2, w3, w4, w5;
	logic [7:0] rq [$];
	logic [3:0] wq [$];
	logic [15:0] ln [5];
	logic [7:0] mem [24];
	int n_errors = 0, samples_checked = 0, n;
	pwg_top dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.mode_wide(mode_wide), .wave_out_two(w2), .wave_out_three(w3),
		.wave_out_four(w4), .wave_out_five(w5));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic cmp(logic [7:0] got, logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Settled sample, one step past the edge, so no race with the driver
	always @(posedge clk) begin
		#1;
		if (reg_rd === 1'b1 && rq.size() > 0) cmp(reg_rdata, rq.pop_front());
		if (wq.size() > 0) cmp({4'h0, w5, w4, w3, w2}, {4'h0, wq.pop_front()});
	end
	task automatic results;
		$display("errors %0d checked %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic op(logic w, logic r, logic [15:0] a, logic [7:0] d);
		@(negedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] d);
		op(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] e);
		rq.push_back(e);
		op(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic idle(int c);
		repeat (c) op(1'b0, 1'b0, 16'h0000, 8'h00);
	endtask
	// Pin index 0..3 is pins 2..5; even pins sit on the odd address
	function automatic logic [15:0] ad(int p, int k);
		return PAIR_BASE[p / 2] + 16'(2 * k + (p % 2 == 0 ? 1 : 0));
	endfunction
	task automatic pexp(int p, int periods, int tail);
		for (int i = 0; i < periods; i++) begin
			for (int k = 0; k < SUB_NUM; k++) begin
				repeat (ln[k] > 0 ? ln[k] : 1) wq.push_back(k % 2 == 0 ? 4'(1 << p) : 4'h0);
			end
		end
		repeat (tail) wq.push_back(4'h0);
	endtask
	task automatic drain;
		for (int i = 0; wq.size() > 0 || rq.size() > 0; i++) begin
			if (i > 2000) begin
				n_errors++;
				results();
			end
			idle(1);
		end
	endtask
	task automatic lens_one(int p);
		for (int k = 0; k < SUB_NUM; k++) begin
			ln[k] = 16'h0001;
			wr(ad(p, k), 8'h01);
		end
	endtask
	initial begin
		void'($urandom(24));
		repeat (8) @(negedge clk);
		nrst <= 1'b1;
		for (int a = 16'h108B; a <= 16'h10A4; a++) rd(16'(a), 8'h00); // REG
		$display("test reset values done");
		for (int i = 0; i < 24; i++) begin
			mem[i] = 8'($urandom());
			if (i % 12 < 10) wr(16'h108C + 16'(i), mem[i]);
		end
		wr(16'h10A4, 8'h5A);
		for (int i = 0; i < 24; i++) begin
			if (i % 12 < 10) rd(16'h108C + 16'(i), mem[i]); // REG
		end
		rd(16'h10A4, 8'h00); // REG
		$display("test register access done");
		for (int p = 0; p < PIN_NUM; p++) begin
			for (int k = 0; k < SUB_NUM; k++) begin
				ln[k] = 16'($urandom_range(0, 3));
				wr(ad(p, k), ln[k][7:0]);
			end
			n = $urandom_range(1, 3);
			wr(ad(p, COUNT_IDX), 8'(n));
			pexp(p, n, 2);
			drain();
			rd(ad(p, COUNT_IDX), 8'h00);
		end
		$display("test narrow periods done");
		lens_one(0);
		wr(ad(0, COUNT_IDX), 8'h05);
		pexp(0, 5, 2);
		idle(2);
		rd(ad(0, COUNT_IDX), 8'h05);
		idle(9);
		rd(ad(0, COUNT_IDX), 8'h03);
		drain();
		$display("test live count done");
		lens_one(1);
		wr(ad(1, COUNT_IDX), 8'h00);
		pexp(1, 6, 0);
		idle(4);
		rd(ad(1, COUNT_IDX), 8'h00);
		drain();
		wr(ad(1, COUNT_IDX), 8'h01);
		pexp(1, 1, 2);
		drain();
		$display("test endless done");
		mode_wide <= 2'h2;
		lens_one(2);
		// Upper bytes still hold narrow-test lengths; clear all but subperiod 1
		for (int k = 0; k < SUB_NUM; k++) wr(ad(3, k), k == 0 ? 8'h01 : 8'h00);
		wr(ad(2, 0), 8'h00);
		ln[0] = 16'h0100;
		wr(ad(3, COUNT_IDX), 8'h00);
		wr(ad(2, COUNT_IDX), 8'h01);
		pexp(2, 1, 2);
		drain();
		$display("test wide lengths done");
		wr(ad(3, 0), 8'h00);
		wr(ad(3, COUNT_IDX), 8'h01);
		wr(ad(2, COUNT_IDX), 8'h00);
		idle(2);
		rd(ad(3, COUNT_IDX), 8'h01);
		idle(4);
		rd(ad(2, COUNT_IDX), 8'h00);
		idle(4);
		rd(ad(2, COUNT_IDX), 8'hFE);
		idle(1);
		// Back-to-back pair: live lower byte would already be FD
		rd(ad(3, COUNT_IDX), 8'h00);
		rd(ad(2, COUNT_IDX), 8'hFE);
		idle(1);
		$display("test wide count done");
		@(negedge clk);
		nrst <= 1'b0;
		repeat (3) wq.push_back(4'h0); // REG
		idle(3);
		@(negedge clk);
		nrst <= 1'b1;
		repeat (2) wq.push_back(4'h0); // REG
		rd(ad(2, COUNT_IDX), 8'h00); // REG
		rd(ad(3, 0), 8'h00); // REG
		drain();
		$display("test mid-run reset done");
		results();
	end
endmodule
